// File: hw/mcqs_pkg.sv
package mcqs_pkg;
  // register addresses on the serial register port
  localparam logic [7:0] ADDR_MOTION_FEAT = 8'h09;
  localparam logic [7:0] ADDR_QUEUE_STAT = 8'h0a;
  localparam logic [7:0] ADDR_QUEUE_RIDX = 8'h0b;
  localparam logic [7:0] ADDR_QUEUE_WIDX = 8'h0c;
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h0d;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h12;
  // reset values
  localparam logic [7:0] RST_MOTION_FEAT = 8'h00;
  localparam logic [7:0] RST_QUEUE_STAT = 8'h01;
  localparam logic [7:0] RST_INDEX = 8'h00;
  // motion control field positions
  localparam int MC_TILT_FLIP = 0;
  localparam int MC_LATCH = 1;
  localparam int MC_ANY_MOVE = 2;
  localparam int MC_SHAKE = 3;
  localparam int MC_TILT35 = 4;
  localparam int MC_Z_SENSE = 5;
  localparam int MC_UNFILT = 6;
  localparam int MC_MRESET = 7;
  // queue status field positions
  localparam int QS_EMPTY = 0;
  localparam int QS_FULL = 1;
  localparam int QS_LEVEL = 2;
  // queue geometry
  localparam int QUEUE_DEPTH = 32;
  localparam int INDEX_W = 6;
  localparam int WRAP_BIT = 5;
  localparam logic [5:0] DEF_THRESHOLD = 6'h10;
  localparam int SAMPLE_W = 48;
  localparam int STAGE_DEPTH = 8;
endpackage

// File: hw/mcqs_stage_fifo.sv
`timescale 1ns/1ns
module mcqs_stage_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  // full and empty from pointers with an extra wrap bit
  assign o_ready = (wp_reg[AW-1:0] != rp_reg[AW-1:0])
    || (wp_reg[AW] == rp_reg[AW]);
  assign o_valid = wp_reg != rp_reg;
  assign o_data = mem_reg[rp_reg[AW-1:0]];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // pointer next state
  always_comb
  begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push)
      wp_next = wp_reg + 1'b1;
    if (pop)
      rp_next = rp_reg + 1'b1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // storage has no reset, data only valid behind valid
  always_ff @(posedge i_mclk)
  begin
    if (push)
      mem_reg[wp_reg[AW-1:0]] <= i_data;
  end
endmodule // mcqs_stage_fifo

// File: hw/mcqs_queue_flags.sv
`timescale 1ns/1ns
module mcqs_queue_flags #(
  parameter int IW = 6
) (
  input wire logic [IW-1:0] i_widx,
  input wire logic [IW-1:0] i_ridx,
  input wire logic [IW-1:0] i_threshold,
  output logic o_empty,
  output logic o_full,
  output logic o_level,
  output logic [IW-1:0] o_count
);
  ////////////////////////////////////////////////////////////////////////
  // purely combinational: flags are live, never registered
  assign o_count = i_widx - i_ridx;
  assign o_empty = i_widx == i_ridx;
  assign o_full = (i_widx[IW-2:0] == i_ridx[IW-2:0])
    && (i_widx[IW-1] != i_ridx[IW-1]);
  assign o_level = o_count >= i_threshold;
endmodule // mcqs_queue_flags

// File: hw/mcqs_regs.sv
`timescale 1ns/1ns
// Behaviour
// - bit0 enables tilt/flip; reset all zero
// - bit1 latches motion outputs
// - bit2 enables any-motion; shake/tilt35 need it
// - bit3 enables shake with any-motion
// - bit4 enables tilt-35 with any-motion
// - bit5 selects z sense
// - bit6 selects unfiltered raw flags
// - bit7 holds motion reset until cleared
// - status flags live, unaffected by interrupt enables
// - status reads 0x01 after reset
// - full bit1, empty bit0, always valid
// - level bit2 set at count >= threshold
// - status bits 7:3 read zero
// - read index six bits, bit5 wrap
// - full/empty compare pointers with wrap bits
// - write index advances on complete sample
// - index registers read-only, reset zero, 7:6 zero
// - queue enabled: 0x0d read returns oldest sample
// - read index advances after full 0x0d-0x12 read
module mcqs_regs #(
  parameter int DEPTH = mcqs_pkg::QUEUE_DEPTH,
  parameter int STAGE = mcqs_pkg::STAGE_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_queue_on,
  input wire logic [5:0] i_threshold,
  input wire logic [7:0] i_live_data [6],
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  input wire logic [47:0] i_sample,
  output logic o_tilt_flip_detect_on,
  output logic o_motion_latch,
  output logic o_any_movement_detect_on,
  output logic o_shake_on,
  output logic o_tilt35_on,
  output logic o_z_sense_select,
  output logic o_unfiltered_flag_select,
  output logic o_motion_reset,
  output logic o_queue_empty,
  output logic o_queue_full,
  output logic o_queue_level_flag
);
  localparam int IW = mcqs_pkg::INDEX_W;
  localparam int SW = mcqs_pkg::SAMPLE_W;

  logic [7:0] mctrl_reg, mctrl_next;
  logic [IW-1:0] widx_reg, widx_next, ridx_reg, ridx_next;
  logic [SW-1:0] store_reg [DEPTH];
  logic [SW-1:0] head_reg, head_next;
  logic [2:0] burst_reg, burst_next;
  logic stg_valid, stg_ready;
  logic [SW-1:0] stg_data;
  logic q_empty, q_full, q_level;
  logic [IW-1:0] q_count;
  logic [IW-1:0] queue_read_index_value, queue_write_index_value;
  logic queue_level_flag;
  logic write_take, read_done;
  logic [7:0] rdata_next, rdata_reg;
  logic [2:0] byte_sel;

  ////////////////////////////////////////////////////////////////////////
  // staging buffer absorbs samples; stalls when the queue is full
  mcqs_stage_fifo #(.WIDTH(SW), .DEPTH(STAGE)) mcqs_stage_fifo_inst (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_valid(i_sample_valid),
    .o_ready(o_sample_ready),
    .i_data(i_sample),
    .o_valid(stg_valid),
    .i_ready(stg_ready),
    .o_data(stg_data)
  );

  mcqs_queue_flags #(.IW(IW)) mcqs_queue_flags_inst (
    .i_widx(widx_reg),
    .i_ridx(ridx_reg),
    .i_threshold(i_threshold),
    .o_empty(q_empty),
    .o_full(q_full),
    .o_level(q_level),
    .o_count(q_count)
  );

  assign queue_read_index_value = ridx_reg;
  assign queue_write_index_value = widx_reg;
  assign queue_level_flag = q_level;
  // only whole samples (x,y,z) enter; no overwrite when full
  assign stg_ready = !q_full;
  assign write_take = stg_valid && stg_ready;

  ////////////////////////////////////////////////////////////////////////
  // motion control: write-only, software-held reset bit
  always_comb
  begin
    mctrl_next = mctrl_reg;
    if (i_reg_wr && i_reg_addr == mcqs_pkg::ADDR_MOTION_FEAT)
      mctrl_next = i_reg_wdata; // no self clear
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      mctrl_reg <= mcqs_pkg::RST_MOTION_FEAT;
    else
      mctrl_reg <= mctrl_next;
  end

  // dependent features gated by the any-motion enable
  assign o_tilt_flip_detect_on = mctrl_reg[mcqs_pkg::MC_TILT_FLIP];
  assign o_motion_latch = mctrl_reg[mcqs_pkg::MC_LATCH];
  assign o_any_movement_detect_on =
    mctrl_reg[mcqs_pkg::MC_ANY_MOVE];
  assign o_shake_on = mctrl_reg[mcqs_pkg::MC_SHAKE]
    && mctrl_reg[mcqs_pkg::MC_ANY_MOVE];
  assign o_tilt35_on = mctrl_reg[mcqs_pkg::MC_TILT35]
    && mctrl_reg[mcqs_pkg::MC_ANY_MOVE];
  assign o_z_sense_select = mctrl_reg[mcqs_pkg::MC_Z_SENSE];
  assign o_unfiltered_flag_select =
    mctrl_reg[mcqs_pkg::MC_UNFILT];
  assign o_motion_reset = mctrl_reg[mcqs_pkg::MC_MRESET];

  // control bits follow writes and hardware never clears them
  a_ctrl_write: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_reg_wr && i_reg_addr == mcqs_pkg::ADDR_MOTION_FEAT
      |=> mctrl_reg == $past(i_reg_wdata))
    else $error("motion control write lost");
  a_mreset_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_motion_reset && !i_reg_wr |=> o_motion_reset)
    else $error("motion reset self cleared");
  a_shake_gate: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_shake_on |-> o_any_movement_detect_on)
    else $error("shake on without any-motion");
  a_tilt35_gate: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_tilt35_on |-> o_any_movement_detect_on)
    else $error("tilt35 on without any-motion");

  ////////////////////////////////////////////////////////////////////////
  // queue indices and burst tracker for 0x0d..0x12 reads
  always_comb
  begin
    widx_next = widx_reg;
    ridx_next = ridx_reg;
    burst_next = burst_reg;
    read_done = 1'b0;
    if (write_take)
      widx_next = widx_reg + 1'b1;
    if (i_reg_rd && i_queue_on)
    begin
      if (i_reg_addr == mcqs_pkg::ADDR_DATA_FIRST)
        burst_next = 3'h1;
      else if (burst_reg != 3'h0
        && i_reg_addr == mcqs_pkg::ADDR_DATA_FIRST + {5'h00, burst_reg})
      begin
        if (i_reg_addr == mcqs_pkg::ADDR_DATA_LAST)
        begin
          burst_next = 3'h0;
          read_done = !q_empty;
        end
        else
          burst_next = burst_reg + 3'h1;
      end
      else
        burst_next = 3'h0;
    end
    if (read_done)
      ridx_next = ridx_reg + 1'b1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      widx_reg <= mcqs_pkg::RST_INDEX[IW-1:0];
      ridx_reg <= mcqs_pkg::RST_INDEX[IW-1:0];
      burst_reg <= 3'h0;
    end
    else
    begin
      widx_reg <= widx_next;
      ridx_reg <= ridx_next;
      burst_reg <= burst_next;
    end
  end

  // indices step by one only on a taken sample or a completed burst
  a_widx_step: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    write_take |=> widx_reg == 6'($past(widx_reg) + 6'h01))
    else $error("write index did not step");
  a_ridx_step: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    read_done |=> ridx_reg == 6'($past(ridx_reg) + 6'h01))
    else $error("read index did not step");
  a_ridx_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !read_done |=> $stable(ridx_reg))
    else $error("read index moved without full read");
  a_wr_full: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    q_full |-> !write_take)
    else $error("write into full queue");
  // burst tracker never runs past the last data byte
  a_burst_bound: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    burst_reg <= 3'h5)
    else $error("burst tracker out of range");

  // sample storage, physical address is the low five index bits
  always_ff @(posedge i_mclk)
  begin
    if (write_take)
      store_reg[widx_reg[IW-2:0]] <= stg_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // head sample captured on 0x0d so the burst sees a stable word
  always_comb
  begin
    head_next = head_reg;
    if (i_reg_rd && i_reg_addr == mcqs_pkg::ADDR_DATA_FIRST)
      head_next = store_reg[ridx_reg[IW-2:0]];
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      head_reg <= '0;
    else
      head_reg <= head_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; status is live flags, reserved bits read zero
  assign byte_sel = 3'(i_reg_addr - mcqs_pkg::ADDR_DATA_FIRST);
  always_comb
  begin
    rdata_next = rdata_reg;
    if (i_reg_rd)
    begin
      rdata_next = 8'h00;
      if (i_reg_addr == mcqs_pkg::ADDR_QUEUE_STAT)
        rdata_next = {5'h00, q_level, q_full, q_empty};
      else if (i_reg_addr == mcqs_pkg::ADDR_QUEUE_RIDX)
        rdata_next = {2'h0, queue_read_index_value};
      else if (i_reg_addr == mcqs_pkg::ADDR_QUEUE_WIDX)
        rdata_next = {2'h0, queue_write_index_value};
      else if (i_reg_addr >= mcqs_pkg::ADDR_DATA_FIRST
        && i_reg_addr <= mcqs_pkg::ADDR_DATA_LAST)
      begin
        if (i_queue_on && i_reg_addr == mcqs_pkg::ADDR_DATA_FIRST)
          rdata_next = store_reg[ridx_reg[IW-2:0]][7:0];
        else if (i_queue_on && burst_reg != 3'h0)
          rdata_next = head_reg[8*byte_sel +: 8];
        else
          rdata_next = i_live_data[byte_sel];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign o_reg_rdata = rdata_reg;
  // live flags, independent of any interrupt enable
  assign o_queue_empty = q_empty;
  assign o_queue_full = q_full;
  assign o_queue_level_flag = queue_level_flag;

  // flags are checked against the raw indices, not the flag module
  a_status_reset: assert property (
    @(posedge i_mclk)
    $rose(i_rst_b) |-> {5'h00, q_level, q_full, q_empty}
      == mcqs_pkg::RST_QUEUE_STAT)
    else $error("status not 0x01 after reset");
  a_empty_equal: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_queue_empty == (widx_reg == ridx_reg))
    else $error("empty flag mismatch");
  a_full_wrap: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_queue_full == (widx_reg[5] != ridx_reg[5]
      && widx_reg[4:0] == ridx_reg[4:0]))
    else $error("full flag mismatch");
  a_level_thresh: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_queue_level_flag == (6'(widx_reg - ridx_reg) >= i_threshold))
    else $error("level flag wrong");
  a_count_diff: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    q_count == 6'(widx_reg - ridx_reg))
    else $error("stored count wrong");

  // read data one cycle after the strobe, reserved bits zero
  a_stat_rdata: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_reg_rd && i_reg_addr == mcqs_pkg::ADDR_QUEUE_STAT
      |=> o_reg_rdata == {5'h00, $past(q_level), $past(q_full),
        $past(q_empty)})
    else $error("status read data wrong");
  a_index_rdata: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_reg_rd && i_reg_addr == mcqs_pkg::ADDR_QUEUE_RIDX
      |=> o_reg_rdata == {2'h0, $past(ridx_reg)})
    else $error("read index read data wrong");
endmodule // mcqs_regs

// File: sim/tb.sv
`timescale 1ns/1ns
module tb;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic i_queue_on = 1'b0;
  logic [5:0] i_threshold = mcqs_pkg::DEF_THRESHOLD;
  logic [7:0] live [6];
  logic i_sample_valid = 1'b0;
  logic [47:0] i_sample = 48'h0;
  logic o_sample_ready;
  wire [7:0] ctl;
  logic o_queue_empty, o_queue_full, o_queue_level_flag;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int acc = 0;
  int rdn = 0;
  logic pend = 1'b0;
  logic [7:0] exp_q [$];
  logic [47:0] samp [$];
  logic [31:0] seed = 32'h0000_1389;

  mcqs_regs #(.DEPTH(mcqs_pkg::QUEUE_DEPTH), .STAGE(mcqs_pkg::STAGE_DEPTH))
  mcqs_regs_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_queue_on(i_queue_on),
    .i_threshold(i_threshold), .i_live_data(live),
    .i_sample_valid(i_sample_valid), .o_sample_ready(o_sample_ready),
    .i_sample(i_sample), .o_tilt_flip_detect_on(ctl[0]),
    .o_motion_latch(ctl[1]), .o_any_movement_detect_on(ctl[2]),
    .o_shake_on(ctl[3]), .o_tilt35_on(ctl[4]), .o_z_sense_select(ctl[5]),
    .o_unfiltered_flag_select(ctl[6]), .o_motion_reset(ctl[7]),
    .o_queue_empty(o_queue_empty), .o_queue_full(o_queue_full),
    .o_queue_level_flag(o_queue_level_flag));

  ////////////////////////////////////////////////////////////////////////////
  // clock, cycle ceiling and shared helpers
  always #4 i_mclk = ~i_mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a hang would otherwise stall the run forever
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read monitor: data lands one cycle after the read strobe is taken
  always @(posedge i_mclk) pend <= i_reg_rd;
  always @(negedge i_mclk)
  begin
    if (pend)
      check("rdata", o_reg_rdata, exp_q.pop_front());
  end

  // strobe stays high across calls so bursts run back to back
  task automatic rd(logic [7:0] a, logic [7:0] e);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    exp_q.push_back(e);
    @(negedge i_mclk);
  endtask

  task automatic idle(int n);
    i_reg_rd = 1'b0;
    i_sample_valid = 1'b0;
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
    @(negedge i_mclk);
  endtask

  // shake and tilt-35 only run with any-movement detection on
  task automatic mc(logic [7:0] d);
    logic [7:0] e;
    e = d;
    e[3] = d[3] & d[2];
    e[4] = d[4] & d[2];
    wr(mcqs_pkg::ADDR_MOTION_FEAT, d);
    check("ctl", ctl, e);
    check("ctl", ctl, e);
  endtask

  // model: queue holds min(accepted, read+32), the rest waits in staging
  task automatic status();
    int w;
    logic [5:0] cnt;
    logic [7:0] st;
    idle(4);
    w = (acc < rdn + 32) ? acc : rdn + 32;
    cnt = 6'(w - rdn);
    st = {5'h00, cnt >= i_threshold, cnt == 6'h20, cnt == 6'h00};
    check("flags", {o_queue_level_flag, o_queue_full, o_queue_empty},
      st[2:0]);
    rd(mcqs_pkg::ADDR_QUEUE_STAT, st);
    rd(mcqs_pkg::ADDR_QUEUE_RIDX, {2'b00, 6'(rdn)});
    rd(mcqs_pkg::ADDR_QUEUE_WIDX, {2'b00, 6'(w)});
    idle(1);
  endtask

  // valid and data held until an edge sees ready high, giving up after 20 edges
  task automatic push(output bit ok);
    logic [47:0] s;
    s = 48'({rnd(), rnd()});
    i_sample_valid = 1'b1;
    i_sample = s;
    ok = 1'b0;
    for (int t = 0; t < 20 && !ok; t++)
    begin
      ok = o_sample_ready;
      @(negedge i_mclk);
    end
    if (ok)
    begin
      samp.push_back(s);
      acc++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    bit ok;
    foreach (live[k]) live[k] = 8'(rnd());
    repeat (16) @(negedge i_mclk);
    i_rst_b = 1'b1;
    check("ctl", ctl, 8'h00);
    status();
    rd(mcqs_pkg::ADDR_MOTION_FEAT, 8'h00);
    rd(8'h3f, 8'h00);
    rd(mcqs_pkg::ADDR_DATA_FIRST, live[0]);
    idle(2);
    $display("test reset done");
    for (int b = 0; b < 8; b++) mc(8'h01 << b);
    mc(8'h18);
    mc(8'h1c);
    repeat (6) mc(8'(rnd()));
    mc(8'h80);
    idle(5);
    check("hold", ctl, 8'h80);
    wr(mcqs_pkg::ADDR_QUEUE_STAT, 8'hff);
    check("ignored", ctl, 8'h80);
    mc(8'h00);
    $display("test motion control done");
    i_queue_on = 1'b1;
    ok = 1'b1;
    while (ok && acc < 64)
    begin
      push(ok);
      if (acc == 15 || acc == 16 || acc == 32) status();
    end
    check("accepted", 48'(acc), 48'(40));
    check("ready", 48'(o_sample_ready), 48'(0));
    status();
    $display("test fill until refused done");
    rd(mcqs_pkg::ADDR_DATA_FIRST, samp[0][7:0]);
    rd(8'h0e, samp[0][15:8]);
    // queue still full after the cut burst: level and full, not empty
    rd(mcqs_pkg::ADDR_QUEUE_STAT, 8'h06);
    status();
    $display("test aborted burst done");
    i_threshold = 6'(rnd() % 32 + 1);
    while (rdn < acc)
    begin
      for (int k = 0; k < 6; k++)
        rd(8'h0d + 8'(k), samp[rdn][8*k +: 8]);
      rdn++;
      status();
    end
    $display("test drain done");
    check("pending", 48'(exp_q.size()), 48'(0));
    report_and_stop();
  end
endmodule // tb
